// File: rtl/product_quotient_unit.v
// Product/quotient unit: multiply and divide pipeline beside the integer pipeline.
// Function
// [RL1] Own pipeline keeps advancing whatever the integer pipeline does.
// [RL2] 32x16 booth array; short multiplies one pass, full multiplies two.
// [RL3] Pass count depends only on the second operand; here also on whether the op is signed.
// [RL4] Operand size is detected from values, not selected by software.
// [RL5] Short multiply every clock; full multiply at most every second clock.
// [RL6] Back-to-back full multiplies stall issue until the array is free.
// [RL7] Divide is iterative, one quotient bit per clock.
// [RL8] Divider checks dividend sign extension for its effective width.
// [RL9] Skip 23, 15 or 7 iterations for 8, 16, 24-bit dividends.
// [RL10] New issues during an active divide stall until it completes, except product_to_gpr in its final cycle.
// [RL11] Multiply latency/repeat 1/1 or 2/2; product_to_gpr 2/1 or 3/2.
// [RL12] Divide latency/repeat 12/11, 19/18, 26/25, 33/32 by dividend width.
// [RL13] Multiplies other than product_to_gpr and divides write upper and bottom words; reads copy them out.
// [RL14] product_to_gpr returns low product word directly, result pair untouched.
// [RL15] Accumulate adds the product to the combined result pair.
// [RL16] Deduct subtracts the product from the combined result pair.
// [RL17] A read before the pending result is written stalls until it is.
// [RL18] Unsigned variants treat operands unsigned, signed ones two's complement.
`timescale 1ns/1ps
`include "pqu_regs.vh"
module product_quotient_unit (
   input  wire        clock_in,
   input  wire        rst_n_in,
   input  wire        issue_valid_in,
   input  wire [3:0]  issue_op_in,
   input  wire [31:0] first_source_operand_in,
   input  wire [31:0] second_operand_in,
   output wire        issue_stall_out,
   output reg         gpr_valid_out,
   output reg  [31:0] gpr_data_out,
   output wire        busy_out
);

   function op_is_mul;
      input [3:0] op;
      begin
         case (op)
            `OP_SIGNED_PRODUCT,
            `OP_UNSIGNED_PRODUCT,
            `OP_PRODUCT_ACC,
            `OP_UNSIGNED_ACC,
            `OP_PRODUCT_DEDUCT,
            `OP_UNSIGNED_DEDUCT,
            `OP_PRODUCT_TO_GPR: op_is_mul = 1'b1;
            default:            op_is_mul = 1'b0;
         endcase
      end
   endfunction

   function op_is_div;
      input [3:0] op;
      begin
         case (op)
            `OP_SIGNED_QUOTIENT,
            `OP_UNSIGNED_QUOTIENT: op_is_div = 1'b1;
            default:               op_is_div = 1'b0;
         endcase
      end
   endfunction

   function op_is_read;
      input [3:0] op;
      begin
         case (op)
            `OP_READ_UPPER,
            `OP_READ_BOTTOM: op_is_read = 1'b1;
            default:         op_is_read = 1'b0;
         endcase
      end
   endfunction

   function op_signed;
      input [3:0] op;
      begin
         case (op)
            `OP_SIGNED_PRODUCT,
            `OP_PRODUCT_ACC,
            `OP_PRODUCT_DEDUCT,
            `OP_PRODUCT_TO_GPR,
            `OP_SIGNED_QUOTIENT: op_signed = 1'b1;
            default:             op_signed = 1'b0;
         endcase
      end
   endfunction

   function [1:0] op_mode;
      input [3:0] op;
      begin
         case (op)
            `OP_PRODUCT_ACC,
            `OP_UNSIGNED_ACC:    op_mode = `MODE_ADD;
            `OP_PRODUCT_DEDUCT,
            `OP_UNSIGNED_DEDUCT: op_mode = `MODE_SUB;
            default:             op_mode = `MODE_LOAD;
         endcase
      end
   endfunction

   // True when the operand is a sign or zero extension of its low half.
   function fits_half;
      input [31:0] v;
      input        s;
      begin
         if (s)
            fits_half = (v[31:15] == 17'h00000) | (v[31:15] == 17'h1ffff);
         else
            fits_half = v[31:16] == 16'h0000;
      end
   endfunction

   reg  [31:0] upper_result_word;
   reg  [31:0] bottom_result_word;
   reg         p2_pending;
   reg  [3:0]  p2_op;
   reg  [32:0] p2_mcand;
   reg  [15:0] p2_bhi;
   reg  [49:0] p2_part;
   reg         gpr_pipe_valid;
   reg  [31:0] gpr_pipe_data;
   reg         blocked;
   reg  [63:0] next_pair;

   wire [3:0]  op = issue_op_in;
   wire        is_mul = op_is_mul(op);
   wire        is_div = op_is_div(op);
   wire        is_read = op_is_read(op);
   wire        sgn = op_signed(op);

   // Only the second operand, read signed or unsigned by the op, decides the pass count.
   wire        half = fits_half(second_operand_in, sgn); // [RL3] [RL4]

   wire        div_busy;
   wire        div_last;
   wire        div_done;
   wire [31:0] div_quo;
   wire [31:0] div_rem;

   wire        take = issue_valid_in & ~blocked;
   wire        start_long = take & is_mul & ~half;
   wire        mul_done = p2_pending | (take & is_mul & half);
   wire [3:0]  done_op = p2_pending ? p2_op : op;
   wire        done_to_gpr = done_op == `OP_PRODUCT_TO_GPR;
   wire        p2_sgn = op_signed(p2_op);

   wire [32:0] mcand_new = {sgn & first_source_operand_in[31], first_source_operand_in}; // [RL18]
   wire [16:0] mplier_new = {sgn & half & second_operand_in[15], second_operand_in[15:0]};
   wire [32:0] mcand = p2_pending ? p2_mcand : mcand_new;
   wire [16:0] mplier = p2_pending ? {p2_sgn & p2_bhi[15], p2_bhi} : mplier_new;
   wire [49:0] pass_prod;

   // One shared array: the second pass of a full multiply owns it for a cycle.
   booth_array u_array (
      .multiplicand_in (mcand),
      .multiplier_in   (mplier),
      .product_out     (pass_prod)
   ); // [RL2]

   wire [63:0] pass_sext = {{14{pass_prod[49]}}, pass_prod};
   wire [63:0] part_sext = {{14{p2_part[49]}}, p2_part};
   wire [63:0] full_prod = p2_pending ? (pass_sext << `HALF_BITS) + part_sext : pass_sext;

   // A finishing divide is forwarded so its result is usable in the same cycle.
   wire [31:0] upper_view = div_done ? div_rem : upper_result_word;
   wire [31:0] bottom_view = div_done ? div_quo : bottom_result_word;
   wire [63:0] pair_view = {upper_view, bottom_view};

   early_in_divider u_divider (
      .clock_in      (clock_in),
      .rst_n_in      (rst_n_in),
      .start_in      (take & is_div),
      .signed_in     (sgn),
      .dividend_in   (first_source_operand_in),
      .divisor_in    (second_operand_in),
      .busy_out      (div_busy),
      .last_out      (div_last),
      .done_out      (div_done),
      .quotient_out  (div_quo),
      .remainder_out (div_rem)
   );

   always @* begin
      next_pair = full_prod;
      case (op_mode(done_op))
         `MODE_ADD: next_pair = pair_view + full_prod; // [RL15]
         `MODE_SUB: next_pair = pair_view - full_prod; // [RL16]
         default:   next_pair = full_prod;
      endcase
   end

   always @* begin
      blocked = 1'b0;
      // The array is busy with a second pass, and its result is not yet written.
      if (p2_pending)
         blocked = 1'b1; // [RL5] [RL6] [RL17]
      // Only product_to_gpr may slip into the final divide cycle; it leaves the pair alone.
      if (div_busy & ~(div_last & (op == `OP_PRODUCT_TO_GPR)))
         blocked = 1'b1; // [RL10] [RL17]
      // A read would collide with a product_to_gpr result leaving on the same port.
      if (is_read & gpr_pipe_valid)
         blocked = 1'b1;
   end

   assign issue_stall_out = issue_valid_in & blocked;
   assign busy_out = p2_pending | div_busy | div_done | gpr_pipe_valid;

   // The unit has no stall input, so every stage advances on every clock.
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         p2_pending <= 1'b0;
         p2_op      <= 4'h0;
         p2_mcand   <= 33'h0;
         p2_bhi     <= 16'h0;
         p2_part    <= 50'h0;
      end else begin
         p2_pending <= start_long; // [RL1] [RL2]
         if (start_long) begin
            p2_op    <= op;
            p2_mcand <= mcand_new;
            p2_bhi   <= second_operand_in[31:16];
            p2_part  <= pass_prod;
         end
      end
   end

   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         upper_result_word  <= 32'h0;
         bottom_result_word <= 32'h0;
      end else if (mul_done & ~done_to_gpr) begin
         upper_result_word  <= next_pair[63:32]; // [RL11] [RL13]
         bottom_result_word <= next_pair[31:0];
      end else if (div_done) begin
         upper_result_word  <= div_rem; // [RL13]
         bottom_result_word <= div_quo;
      end
   end

   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         gpr_pipe_valid <= 1'b0;
         gpr_pipe_data  <= 32'h0;
      end else begin
         gpr_pipe_valid <= mul_done & done_to_gpr; // [RL11] [RL14]
         if (mul_done & done_to_gpr)
            gpr_pipe_data <= full_prod[31:0];
      end
   end

   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         gpr_valid_out <= 1'b0;
         gpr_data_out  <= 32'h0;
      end else begin
         gpr_valid_out <= (take & is_read) | gpr_pipe_valid;
         if (take & is_read)
            gpr_data_out <= (op == `OP_READ_UPPER) ? upper_view : bottom_view; // [RL13]
         else if (gpr_pipe_valid)
            gpr_data_out <= gpr_pipe_data; // [RL14]
      end
   end

endmodule

// File: pkg/pqu_regs.vh
// Shared constants of the product/quotient unit: operation codes, widths, divide timing.
`ifndef PQU_REGS_VH
`define PQU_REGS_VH

// Operation codes on the issue port.
`define OP_SIGNED_PRODUCT    4'h0
`define OP_UNSIGNED_PRODUCT  4'h1
`define OP_PRODUCT_ACC       4'h2
`define OP_UNSIGNED_ACC      4'h3
`define OP_PRODUCT_DEDUCT    4'h4
`define OP_UNSIGNED_DEDUCT   4'h5
`define OP_PRODUCT_TO_GPR    4'h6
`define OP_SIGNED_QUOTIENT   4'h7
`define OP_UNSIGNED_QUOTIENT 4'h8
`define OP_READ_UPPER        4'h9
`define OP_READ_BOTTOM       4'ha

// Accumulation modes of the upper/bottom result pair.
`define MODE_LOAD            2'h0
`define MODE_ADD             2'h1
`define MODE_SUB             2'h2

// Multiplier split: the second operand is taken in halves of this many bits.
`define HALF_BITS            16

// Dividend width classes, iterations skipped and latency in clocks.
`define DIV_WORD             6'h20
`define DIV_W8               6'h08
`define DIV_W16              6'h10
`define DIV_W24              6'h18
`define DIV_SKIP_W8          5'h17
`define DIV_SKIP_W16         5'h0f
`define DIV_SKIP_W24         5'h07
`define DIV_SKIP_W32         5'h00
`define DIV_LAT_W8           6'h0c
`define DIV_LAT_W16          6'h13
`define DIV_LAT_W24          6'h1a
`define DIV_LAT_W32          6'h21
`define DIV_CNT_STEP         6'h01

`endif

// File: rtl/booth_array.v
// Radix-4 booth recoded 33x17 signed multiplier array, one pass per use.
`timescale 1ns/1ps
module booth_array (
   input  wire [32:0] multiplicand_in,
   input  wire [16:0] multiplier_in,
   output wire [49:0] product_out
);

   function [50:0] booth_pp;
      input [2:0]  grp;
      input [32:0] mc;
      reg   [50:0] ext;
      begin
         ext = {{18{mc[32]}}, mc};
         case (grp)
            3'h1, 3'h2: booth_pp = ext;
            3'h3:       booth_pp = ext << 1;
            3'h4:       booth_pp = -(ext << 1);
            3'h5, 3'h6: booth_pp = -ext;
            default:    booth_pp = 51'h0;
         endcase
      end
   endfunction

   wire [18:0] mpad = {multiplier_in[16], multiplier_in, 1'b0};
   wire [50:0] acc [0:9];

   assign acc[0] = 51'h0;

   // Nine recoded digits cover the sign-extended 18-bit multiplier.
   genvar i;
   generate
      for (i = 0; i < 9; i = i + 1) begin : g_digit
         assign acc[i+1] = acc[i] + (booth_pp(mpad[2*i+2:2*i], multiplicand_in) << (2*i));
      end
   endgenerate

   assign product_out = acc[9][49:0];

endmodule

// File: rtl/early_in_divider.v
// Iterative one-bit-per-clock divider with early-in dividend width detection.
`timescale 1ns/1ps
`include "pqu_regs.vh"
module early_in_divider (
   input  wire        clock_in,
   input  wire        rst_n_in,
   input  wire        start_in,
   input  wire        signed_in,
   input  wire [31:0] dividend_in,
   input  wire [31:0] divisor_in,
   output wire        busy_out,
   output wire        last_out,
   output reg         done_out,
   output reg  [31:0] quotient_out,
   output reg  [31:0] remainder_out
);

   function [4:0] skip_of;
      input [31:0] v;
      input        s;
      reg   [31:0] x;
      begin
         x = (s & v[31]) ? ~v : v;
         if ((x >> (`DIV_W8 - {5'h00, s})) == 32'h0)
            skip_of = `DIV_SKIP_W8;
         else if ((x >> (`DIV_W16 - {5'h00, s})) == 32'h0)
            skip_of = `DIV_SKIP_W16;
         else if ((x >> (`DIV_W24 - {5'h00, s})) == 32'h0)
            skip_of = `DIV_SKIP_W24;
         else
            skip_of = `DIV_SKIP_W32;
      end
   endfunction

   function [5:0] lat_of;
      input [4:0] skip;
      begin
         case (skip)
            `DIV_SKIP_W8:  lat_of = `DIV_LAT_W8;
            `DIV_SKIP_W16: lat_of = `DIV_LAT_W16;
            `DIV_SKIP_W24: lat_of = `DIV_LAT_W24;
            default:       lat_of = `DIV_LAT_W32;
         endcase
      end
   endfunction

   reg  [5:0]  cnt;
   reg  [5:0]  iters;
   reg  [31:0] rem;
   reg  [31:0] quo;
   reg  [31:0] dvs;
   reg         neg_q;
   reg         neg_r;

   wire [4:0]  skip = skip_of(dividend_in, signed_in); // [RL8]
   wire [31:0] dvd_mag = (signed_in & dividend_in[31]) ? -dividend_in : dividend_in; // [RL18]
   wire [31:0] dvs_mag = (signed_in & divisor_in[31]) ? -divisor_in : divisor_in;
   wire [33:0] trial = {1'b0, rem, quo[31]} - {2'b00, dvs};
   wire        step = cnt <= iters;
   wire [31:0] next_rem = trial[33] ? {rem[30:0], quo[31]} : trial[31:0];
   wire [31:0] next_quo = {quo[30:0], ~trial[33]};

   assign busy_out = cnt != 6'h00;
   assign last_out = cnt == `DIV_CNT_STEP;

   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         cnt           <= 6'h00;
         iters         <= 6'h00;
         rem           <= 32'h0;
         quo           <= 32'h0;
         dvs           <= 32'h0;
         neg_q         <= 1'b0;
         neg_r         <= 1'b0;
         done_out      <= 1'b0;
         quotient_out  <= 32'h0;
         remainder_out <= 32'h0;
      end else begin
         done_out <= 1'b0;
         if (start_in) begin
            // The skipped iterations are taken by pre-shifting the dividend magnitude.
            cnt   <= lat_of(skip) - `DIV_CNT_STEP; // [RL12]
            iters <= `DIV_WORD - {1'b0, skip}; // [RL9]
            rem   <= 32'h0;
            quo   <= dvd_mag << skip;
            dvs   <= dvs_mag;
            neg_q <= signed_in & (dividend_in[31] ^ divisor_in[31]);
            neg_r <= signed_in & dividend_in[31];
         end else if (busy_out) begin
            cnt <= cnt - `DIV_CNT_STEP;
            if (step) begin
               rem <= next_rem; // [RL7]
               quo <= next_quo;
            end
            if (last_out) begin
               done_out      <= 1'b1;
               quotient_out  <= neg_q ? -next_quo : next_quo;
               remainder_out <= neg_r ? -next_rem : next_rem;
            end
         end
      end
   end

endmodule

// File: tb/int_pipe_model.sv
// Issuing pipeline model: holds each request until the unit takes it.
`timescale 1ns/1ps
module int_pipe_model (
   input  wire        clock_in,
   input  wire        cmd_in,
   input  wire [3:0]  cmd_op_in,
   input  wire [31:0] cmd_a_in,
   input  wire [31:0] cmd_b_in,
   input  wire        issue_stall_in,
   output reg         cmd_ack_out = 1'b0,
   output reg         issue_valid_out = 1'b0,
   output reg  [3:0]  issue_op_out = 4'h0,
   output reg  [31:0] first_out = 32'h0,
   output reg  [31:0] second_out = 32'h0
);
   // Once a request is taken and no new one follows, the operands flip to their inverse every cycle, so a unit that
   // samples them one cycle late picks up the wrong value; two cycles late they show the right value again.
   always @(posedge clock_in) begin
      cmd_ack_out <= 1'b0;
      if (!(issue_valid_out && issue_stall_in)) begin
         if (cmd_in) begin
            cmd_ack_out <= 1'b1;
            issue_valid_out <= 1'b1;
            issue_op_out <= cmd_op_in;
            first_out <= cmd_a_in;
            second_out <= cmd_b_in;
         end else begin
            issue_valid_out <= 1'b0;
            issue_op_out <= ~issue_op_out;
            first_out <= ~first_out;
            second_out <= ~second_out;
         end
      end
   end
endmodule

// File: tb/pqu_chk.sv
// Assertion checker watching the ports of the product/quotient unit.
`timescale 1ns/1ps
module pqu_chk (
   input wire        clock_in,
   input wire        rst_n_in,
   input wire        issue_valid_in,
   input wire [3:0]  issue_op_in,
   input wire [31:0] first_source_operand_in,
   input wire [31:0] second_operand_in,
   input wire        issue_stall_out,
   input wire        gpr_valid_out,
   input wire [31:0] gpr_data_out,
   input wire        busy_out
);
   function fits(input u, input [31:0] v, input integer n);
      fits = u ? (v >> (n + 1)) == 32'h0 : ($signed(v) >>> n) == 0 || ($signed(v) >>> n) == -1;
   endfunction
   wire       take = issue_valid_in & ~issue_stall_out;
   wire       uns  = issue_op_in == 4'h1 || issue_op_in == 4'h3 || issue_op_in == 4'h5
                     || issue_op_in == 4'h8;
   wire       half = fits(uns, second_operand_in, 15);
   wire       full = take && issue_op_in <= 4'h6 && !half;
   wire       to_gpr = take && issue_op_in == 4'h6;
   wire       rd   = take && (issue_op_in == 4'h9 || issue_op_in == 4'ha);
   reg  [5:0] div_cnt;
   // Counts down the cycles a divide still owns the result pair after it was taken.
   always @(posedge clock_in) begin
      if (!rst_n_in)
         div_cnt <= 6'h00;
      else if (take && (issue_op_in == 4'h7 || issue_op_in == 4'h8))
         div_cnt <= fits(uns, first_source_operand_in, 7) ? 6'h0b :
                    fits(uns, first_source_operand_in, 15) ? 6'h12 :
                    fits(uns, first_source_operand_in, 23) ? 6'h19 : 6'h20;
      else if (div_cnt != 6'h00)
         div_cnt <= div_cnt - 6'h01;
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   property p_full_wait;
      full |=> (issue_valid_in |-> issue_stall_out);
   endproperty
   a_full_wait: assert property (p_full_wait) else $error("full multiply not spaced");
   property p_full_pass;
      full |=> busy_out;
   endproperty
   a_full_pass: assert property (p_full_pass) else $error("no second pass seen");
   property p_short_rate;
      take && issue_op_in <= 4'h6 && half && !busy_out
         |=> !(issue_valid_in && issue_op_in <= 4'h6) || !issue_stall_out;
   endproperty
   a_short_rate: assert property (p_short_rate) else $error("short multiply stalled");
   property p_read_lat;
      rd |=> gpr_valid_out;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read answer late");
   property p_gpr_short;
      to_gpr && half |-> ##2 gpr_valid_out;
   endproperty
   a_gpr_short: assert property (p_gpr_short) else $error("short to_gpr latency");
   property p_gpr_full;
      to_gpr && !half |-> ##3 gpr_valid_out;
   endproperty
   a_gpr_full: assert property (p_gpr_full) else $error("full to_gpr latency");
   property p_div_hold;
      issue_valid_in && (div_cnt > 6'h01 || div_cnt == 6'h01 && issue_op_in != 4'h6)
         |-> issue_stall_out;
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("issue during divide");
   property p_div_free;
      div_cnt == 6'h01 && !to_gpr |=> !(issue_valid_in && issue_op_in == 4'h9) || !issue_stall_out;
   endproperty
   a_div_free: assert property (p_div_free) else $error("divide latency too long");
endmodule
bind product_quotient_unit pqu_chk pqu_chk_inst (
   .clock_in(clock_in),
   .rst_n_in(rst_n_in),
   .issue_valid_in(issue_valid_in),
   .issue_op_in(issue_op_in),
   .first_source_operand_in(first_source_operand_in),
   .second_operand_in(second_operand_in),
   .issue_stall_out(issue_stall_out),
   .gpr_valid_out(gpr_valid_out),
   .gpr_data_out(gpr_data_out),
   .busy_out(busy_out)
);

// File: tb/testbench.sv
// Self-checking bench of the product/quotient unit behind a pipeline issue model.
`timescale 1ns/1ps
module testbench;
   reg         clock_in;
   reg         rst_n_in;
   reg         cmd;
   reg  [3:0]  cmd_op;
   reg  [31:0] cmd_a;
   reg  [31:0] cmd_b;
   wire        ack;
   wire        valid;
   wire [3:0]  op_w;
   wire [31:0] opa;
   wire [31:0] opb;
   wire        stall;
   wire        gpr_valid;
   wire [31:0] gpr_data;
   wire        busy;
   reg  [31:0] got[$];
   reg  [63:0] acc;
   reg  [63:0] pa;
   reg  [63:0] pb;
   reg  [31:0] a;
   reg  [31:0] b;
   reg  [31:0] r;
   reg  [3:0]  op;
   integer     fails;
   integer     samples_checked;
   integer     seed;
   integer     i;
   product_quotient_unit product_quotient_unit_inst (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .issue_valid_in(valid), .issue_op_in(op_w),
      .first_source_operand_in(opa), .second_operand_in(opb), .issue_stall_out(stall),
      .gpr_valid_out(gpr_valid), .gpr_data_out(gpr_data), .busy_out(busy)
   );
   int_pipe_model int_pipe_model_inst (
      .clock_in(clock_in), .cmd_in(cmd), .cmd_op_in(cmd_op), .cmd_a_in(cmd_a),
      .cmd_b_in(cmd_b), .issue_stall_in(stall), .cmd_ack_out(ack), .issue_valid_out(valid),
      .issue_op_out(op_w), .first_out(opa), .second_out(opb)
   );
   initial clock_in = 1'b0;
   always #2 clock_in = ~clock_in;
   always @(posedge clock_in)
      if (gpr_valid === 1'b1)
         got.push_back(gpr_data);
   function [63:0] prod(input s, input [31:0] x, input [31:0] y);
      prod = (s ? {{32{x[31]}}, x} : {32'h0, x}) * (s ? {{32{y[31]}}, y} : {32'h0, y});
   endfunction
   function [63:0] divx(input s, input [31:0] x, input [31:0] y);
      if (s)
         divx = {$signed(x) % $signed(y), $signed(x) / $signed(y)};
      else
         divx = {x % y, x / y};
   endfunction
   function sg(input [3:0] o);
      sg = o == 4'h0 || o == 4'h2 || o == 4'h4 || o == 4'h6 || o == 4'h7;
   endfunction
   // Operand of 8, 16, 24 or 32 significant bits, zero- or sign-extended.
   function [31:0] ext(input [31:0] v, input [1:0] k, input z);
      if (z)
         ext = v >> (24 - 8 * k);
      else
         ext = $signed(v << (24 - 8 * k)) >>> (24 - 8 * k);
   endfunction
   task check(input string what, input [31:0] expected, input [31:0] seen);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== expected) begin
            fails = fails + 1;
            $display("MISMATCH %0s expected %h seen %h", what, expected, seen);
         end
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fails);
         if (fails == 0 && samples_checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task issue(input [3:0] o, input [31:0] x, input [31:0] y);
      integer n;
      begin
         cmd = 1'b1;
         cmd_op = o;
         cmd_a = x;
         cmd_b = y;
         n = 0;
         @(posedge clock_in);
         #1;
         while (ack !== 1'b1 && n < 100) begin
            n = n + 1;
            @(posedge clock_in);
            #1;
         end
         // A request that is never taken must count, not just time out quietly.
         check("issue taken", 32'h1, {31'h0, ack});
      end
   endtask
   task expect_out(input string what, input [31:0] v);
      integer n;
      begin
         n = 0;
         while (got.size() == 0 && n < 100) begin
            n = n + 1;
            @(posedge clock_in);
            #1;
         end
         if (got.size() == 0)
            got.push_back(~v);
         check(what, v, got.pop_front());
      end
   endtask
   task result(input [3:0] o, input [31:0] v);
      begin
         issue(o, $random(seed), $random(seed));
         cmd = 1'b0;
         expect_out("read", v);
         // Every earlier operation has finished once a read has been answered.
         check("busy", 32'h0, {31'h0, busy});
      end
   endtask
   task run(input [3:0] o, input [31:0] x, input [31:0] y);
      begin
         issue(o, x, y);
         pa = prod(sg(o), x, y);
         if (o < 4'h2)
            acc = pa;
         else if (o < 4'h4)
            acc = acc + pa;
         else if (o < 4'h6)
            acc = acc - pa;
         else if (o > 4'h6)
            acc = divx(sg(o), x, y);
      end
   endtask
   initial begin
      #100000;
      fails = fails + 1;
      conclude;
   end
   initial begin
      seed = 32'h9d0a;
      fails = 0;
      samples_checked = 0;
      rst_n_in = 1'b0;
      cmd = 1'b0;
      cmd_op = 4'h0;
      cmd_a = 32'h0;
      cmd_b = 32'h0;
      acc = 64'h0;
      repeat (12) @(posedge clock_in);
      #1;
      rst_n_in = 1'b1;
      result(4'h9, 32'h0);
      result(4'ha, 32'h0);
      for (i = 0; i < 80; i = i + 1) begin
         r = $random(seed);
         op = {1'b0, r[10:8] % 3'h6};
         a = ext($random(seed), r[1:0], r[2]);
         b = ext($random(seed), r[4:3], r[5]);
         run(op, a, b);
         if (r[6])
            run(op, b, a);
         result(4'h9, acc[63:32]);
         result(4'ha, acc[31:0]);
      end
      for (i = 0; i < 20; i = i + 1) begin
         r = $random(seed);
         a = ext($random(seed), r[1:0], r[2]);
         b = ext($random(seed), r[4:3], r[5]);
         pa = prod(1'b1, a, b);
         pb = prod(1'b1, b, a ^ r);
         issue(4'h6, a, b);
         issue(4'h6, b, a ^ r);
         cmd = 1'b0;
         expect_out("to_gpr", pa[31:0]);
         expect_out("to_gpr", pb[31:0]);
         result(4'ha, acc[31:0]);
      end
      for (i = 0; i < 48; i = i + 1) begin
         r = $random(seed);
         op = 4'h7 + {3'h0, i[2]};
         a = ext($random(seed), i[1:0], r[2]);
         b = ($random(seed) | 32'h10) & 32'hfffffff7;
         run(op, a, b);
         if (r[3]) begin
            issue(4'h6, b, a);
            cmd = 1'b0;
            pa = prod(1'b1, b, a);
            expect_out("to_gpr", pa[31:0]);
         end
         result(4'h9, acc[63:32]);
         result(4'ha, acc[31:0]);
      end
      conclude;
   end
endmodule
